/* verilog/epi_map.svh */
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH

// ==========================================
// register offsets (byte addresses)
`define EPI_OFS_SENSE_CTRL 8'h00
`define EPI_OFS_SENSE_STAT 8'h04
`define EPI_OFS_ENABLES 8'h08
`define EPI_OFS_FLAGS 8'h0C

// ==========================================
// field positions
`define EPI_SENSE_A_MSB 1
`define EPI_SENSE_B_MSB 3
`define EPI_ASYNC_POL_BIT 6
`define EPI_BIT_PIN_B 7
`define EPI_BIT_PIN_A 6
`define EPI_BIT_PIN_ASYNC 5

// ==========================================
// reset values
`define EPI_RST_SENSE 4'h0
`define EPI_RST_POL 1'b0
`define EPI_RST_EN 3'h0
`define EPI_RST_FLAGS 3'h0
`define EPI_RST_DATA 32'h0000_0000

`endif

/* verilog/epi_pkg.sv */
package epi_pkg;

    // ==========================================
    // sense modes of the two sampled pins
    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'b00,
        EPI_SENSE_ANY = 2'b01,
        EPI_SENSE_FALL = 2'b10,
        EPI_SENSE_RISE = 2'b11
    } epi_sense_t;

    // ==========================================
    // bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } epi_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } epi_apb_rsp_t;

endpackage

/* verilog/epi_sync.sv */
`timescale 1ns/1ps

module epi_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // levels from outside the clock domain
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds the second stage only
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule

/* verilog/epi_async_capture.sv */
`timescale 1ns/1ps

module epi_async_capture (
    // reset and clear
    input wire logic nrst_i,
    input wire logic clear_i,
    // pin and edge choice
    input wire logic pin_i,
    input wire logic polarity_i,
    output logic captured_o
);

    // polarity folds into the capture clock, so a polarity change can itself
    // look like an edge; software masks the input around such a change
    wire logic cap_clk = polarity_i ? pin_i : ~pin_i;
    wire logic cap_clr = clear_i | ~nrst_i;

    // no dependence on the system clock: edges are kept while it is stopped
    always_ff @(posedge cap_clk or posedge cap_clr) begin
        if (cap_clr) begin
            captured_o <= 1'b0;
        end else begin
            captured_o <= 1'b1;
        end
    end

endmodule

/* verilog/epi_top.sv */
// Contract
// - pin A request raised only with global enable and its own enable set
// - sampled pins A and B are synchronised, edges found from sampled values
// - pin A sense field bits 1:0: low, any change, falling, rising
// - pin B sense field bits 3:2 with the same encoding
// - level mode on an enabled pin requests while the pin stays low
// - async pin polarity in status register bit 6: 0 falling, 1 rising
// - async pin edges captured without the system clock
// - enables: bit 7 pin B, bit 6 pin A, bit 5 async pin
// - pins raise requests even when driven as outputs
// - each enabled pending pin is dispatched to its own vector
// - flags set on events: bit 7 pin B, bit 6 pin A, bit 5 async pin
// - flag cleared by vector acknowledge or by writing one; zero ignored
// - flag of a pin in level mode is held cleared
// - sleep with async pin disabled turns off its buffer, may set flag
`timescale 1ns/1ps
`include "epi_map.svh"

module epi_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register bus
    input wire epi_pkg::epi_apb_req_t apb_req_i,
    output epi_pkg::epi_apb_rsp_t apb_rsp_o,
    // request pins
    input wire logic ext_req_pin_a_i,
    input wire logic ext_req_pin_b_i,
    input wire logic ext_req_pin_async_i,
    // core side
    input wire logic global_ie_i,
    input wire logic [2:0] vec_ack_i,
    input wire logic sleep_buf_off_i,
    // requests to the core
    output logic [2:0] vec_req_o,
    output logic irq_o
);

    // ==========================================
    // state
    logic [3:0] sense_reg;
    logic pol_reg;
    logic [2:0] en_reg;
    logic [2:0] flag_reg;
    logic clr_cap_reg;
    logic [1:0] pin_prev_reg;
    logic cap_prev_reg;

    // ==========================================
    // bus decode
    wire logic acc = apb_req_i.psel & apb_req_i.penable;
    wire logic commit = acc & apb_rsp_o.pready;
    wire logic answer = acc & ~apb_rsp_o.pready;
    wire logic hit_ctrl = (apb_req_i.paddr == `EPI_OFS_SENSE_CTRL);
    wire logic hit_stat = (apb_req_i.paddr == `EPI_OFS_SENSE_STAT);
    wire logic hit_en = (apb_req_i.paddr == `EPI_OFS_ENABLES);
    wire logic hit_flags = (apb_req_i.paddr == `EPI_OFS_FLAGS);
    wire logic hit_any = hit_ctrl | hit_stat | hit_en | hit_flags;
    wire logic wr_lane0 = commit & apb_req_i.pwrite & apb_req_i.pstrb[0];
    wire logic [7:0] wdat = apb_req_i.pwdata[7:0];

    wire logic [7:0] rd_ctrl = {4'h0, sense_reg};
    wire logic [7:0] rd_stat = {1'b0, pol_reg, 6'h00};
    wire logic [7:0] rd_en = {en_reg[1], en_reg[0], en_reg[2], 5'h00};
    wire logic [7:0] rd_flags = {flag_reg[1], flag_reg[0], flag_reg[2], 5'h00};
    wire logic [7:0] rd_mux = hit_ctrl ? rd_ctrl :
                              hit_stat ? rd_stat :
                              hit_en ? rd_en :
                              hit_flags ? rd_flags : 8'h00;

    // bit order inside the block: 0 pin A, 1 pin B, 2 async pin
    wire logic [2:0] wr_bits = {wdat[`EPI_BIT_PIN_ASYNC], wdat[`EPI_BIT_PIN_B],
                                wdat[`EPI_BIT_PIN_A]};

    // ==========================================
    // pin sampling
    // pins are read straight, whatever the port direction is
    logic [2:0] sync_out;
    logic cap_raw;
    wire logic [1:0] pin_sync = sync_out[1:0];
    wire logic cap_sync = sync_out[2];

    epi_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i({cap_raw, ext_req_pin_b_i, ext_req_pin_a_i}),
        .sync_o(sync_out)
    );

    // disabled buffer in sleep reads as low, which may look like an edge
    wire logic buf_off = sleep_buf_off_i & ~en_reg[2];
    wire logic async_pin_eff = ext_req_pin_async_i & ~buf_off;

    epi_async_capture u_cap (
        .nrst_i(nrst_i),
        .clear_i(clr_cap_reg),
        .pin_i(async_pin_eff),
        .polarity_i(pol_reg),
        .captured_o(cap_raw)
    );

    // ==========================================
    // sense decode for the sampled pins
    logic [1:0] lvl_mode;
    logic [1:0] edge_hit;

    for (genvar g = 0; g < 2; g++) begin : g_sense
        wire epi_pkg::epi_sense_t mode = epi_pkg::epi_sense_t'(sense_reg[2*g+1 -: 2]);
        wire logic cur = pin_sync[g];
        wire logic prv = pin_prev_reg[g];
        assign lvl_mode[g] = (mode == epi_pkg::EPI_SENSE_LOW);
        assign edge_hit[g] = ((mode == epi_pkg::EPI_SENSE_ANY) & (cur ^ prv)) |
                             ((mode == epi_pkg::EPI_SENSE_FALL) & prv & ~cur) |
                             ((mode == epi_pkg::EPI_SENSE_RISE) & cur & ~prv);
    end

    // ==========================================
    // flags
    wire logic cap_rise = cap_sync & ~cap_prev_reg;
    wire logic [2:0] set_vec = {cap_rise, edge_hit & ~lvl_mode};
    wire logic [2:0] w1c = (wr_lane0 & hit_flags) ? wr_bits : 3'h0;
    wire logic [2:0] clr_vec = w1c | vec_ack_i;
    // set wins over a clear in the same cycle; level mode forces zero
    wire logic [2:0] flag_next = ((flag_reg & ~clr_vec) | set_vec) &
                                 ~{1'b0, lvl_mode};

    // hold the capture cleared until the synchronised copy has dropped;
    // an edge inside that short window is not kept
    wire logic clr_cap_next = clr_cap_reg ? cap_sync :
                              (clr_vec[2] & cap_sync & ~cap_rise);

    // ==========================================
    // dispatch
    // level mode requests straight from the pin while it is low
    wire logic [2:0] pending = {flag_reg[2],
                                lvl_mode[1] ? ~pin_sync[1] : flag_reg[1],
                                lvl_mode[0] ? ~pin_sync[0] : flag_reg[0]};
    wire logic [2:0] vec_req_next = pending & en_reg & {3{global_ie_i}};
    wire logic irq_next = |vec_req_next;

    // ==========================================
    // bus answer: one wait state, response registered
    wire logic pready_next = answer;
    wire logic pslverr_next = answer & ~hit_any;
    wire logic [31:0] prdata_next = (answer & ~apb_req_i.pwrite) ? {24'h000000, rd_mux} :
                                    `EPI_RST_DATA;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            apb_rsp_o <= '0;
        end else begin
            apb_rsp_o.prdata <= prdata_next;
            apb_rsp_o.pready <= pready_next;
            apb_rsp_o.pslverr <= pslverr_next;
        end
    end

    // ==========================================
    // control registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sense_reg <= `EPI_RST_SENSE;
            pol_reg <= `EPI_RST_POL;
            en_reg <= `EPI_RST_EN;
        end else if (wr_lane0) begin
            if (hit_ctrl) begin
                sense_reg <= wdat[`EPI_SENSE_B_MSB:0];
            end else if (hit_stat) begin
                pol_reg <= wdat[`EPI_ASYNC_POL_BIT];
            end else if (hit_en) begin
                en_reg <= wr_bits;
            end
        end
    end

    // ==========================================
    // flags, edge history, requests
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_reg <= `EPI_RST_FLAGS;
            clr_cap_reg <= 1'b0;
            pin_prev_reg <= 2'b00;
            cap_prev_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            clr_cap_reg <= clr_cap_next;
            pin_prev_reg <= pin_sync;
            cap_prev_reg <= cap_sync;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vec_req_o <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            vec_req_o <= vec_req_next;
            irq_o <= irq_next;
        end
    end

endmodule

/* verification/epi_pin_model.sv */
`timescale 1ns/1ps

module epi_pin_model (
    // pins toward the block: [0] a, [1] b, [2] async
    output logic [2:0] pins_o
);
    // =====
    // idle high, as with pulled-up open-collector sources
    initial pins_o = 3'h7;

    // a level stays until the next call, so a low request is held on
    task automatic drive(input int idx, input logic v);
        pins_o[idx] <= v;
    endtask
endmodule

/* verification/epi_top_properties.sv */
`timescale 1ns/1ps

module epi_top_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // bus
    input wire epi_pkg::epi_apb_req_t apb_req_i,
    input wire epi_pkg::epi_apb_rsp_t apb_rsp_o,
    // pins and core
    input wire logic ext_req_pin_async_i,
    input wire logic global_ie_i,
    input wire logic [2:0] vec_ack_i,
    input wire logic sleep_buf_off_i,
    input wire logic [2:0] vec_req_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence access_start;
        apb_req_i.psel && apb_req_i.penable && !$past(apb_req_i.penable);
    endsequence
    // quiet async pin so no new edge can refill the flag after the ack
    sequence async_quiet;
        (!sleep_buf_off_i && $stable(ext_req_pin_async_i))[*4] ##0 vec_ack_i[2];
    endsequence

    a_ready_wait: assert property (access_start |->
        !apb_rsp_o.pready ##1 apb_rsp_o.pready) else $error("pready wait state wrong");
    a_ready_pulse: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("pready longer than one cycle");
    a_err_decode: assert property (apb_rsp_o.pready |-> apb_rsp_o.pslverr ==
        (apb_req_i.paddr[1:0] != 2'h0 || apb_req_i.paddr > 8'h0C))
        else $error("pslverr does not match address");
    a_rdata_idle: assert property (!apb_rsp_o.pready |-> apb_rsp_o.prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_req_gated: assert property (|vec_req_o |-> $past(global_ie_i))
        else $error("request without global enable");
    a_irq_or: assert property (irq_o == |vec_req_o)
        else $error("irq not the OR of requests");
    a_reset_quiet: assert property ($rose(nrst_i) |-> !irq_o && vec_req_o == 3'h0)
        else $error("request right after reset");
    a_ack_drop: assert property (async_quiet |=> ##1 !vec_req_o[2])
        else $error("async request kept after ack");
endmodule

bind epi_top epi_top_checker i_chk (.sys_clk_i, .nrst_i, .apb_req_i, .apb_rsp_o,
    .ext_req_pin_async_i, .global_ie_i, .vec_ack_i, .sleep_buf_off_i, .vec_req_o, .irq_o);

/* verification/epi_top_test.sv */
`timescale 1ns/1ps
`include "epi_map.svh"

module external_pin_interrupt_unit_test;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    epi_pkg::epi_apb_req_t req = '{pstrb: 4'hF, default: '0};
    epi_pkg::epi_apb_rsp_t rsp;
    logic [2:0] pins;
    logic ie = 1'b0;
    logic [2:0] ack = 3'h0;
    logic sleep_off = 1'b0;
    logic [2:0] vreq;
    logic irq;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int n_tests = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    epi_pin_model i_pins (.pins_o(pins));
    epi_top i_dut (.sys_clk_i, .nrst_i, .apb_req_i(req), .apb_rsp_o(rsp),
        .ext_req_pin_a_i(pins[0]), .ext_req_pin_b_i(pins[1]),
        .ext_req_pin_async_i(pins[2]), .global_ie_i(ie), .vec_ack_i(ack),
        .sleep_buf_off_i(sleep_off), .vec_req_o(vreq), .irq_o(irq));

    // =====
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // entered just after an edge; one idle edge at the end keeps psel from double assignment
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k = 0;
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= {24'h0, d};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge sys_clk_i);
        if (k >= 20) check("pready", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        apb(1'b0, a, 8'h00);
        check(what, {24'h0, exp}, rd);
    endtask

    task automatic edge_chk(input int p, input logic v, input logic hit, input logic [7:0] fb);
        i_pins.drive(p, v);
        wt(5);
        check("edge request", {31'h0, hit}, {31'h0, vreq[p]});
        rdchk(`EPI_OFS_FLAGS, hit ? fb : 8'h00, "edge flag");
        wr(`EPI_OFS_FLAGS, 8'h00);
        rdchk(`EPI_OFS_FLAGS, hit ? fb : 8'h00, "zero write kept");
        wr(`EPI_OFS_FLAGS, fb);
        rdchk(`EPI_OFS_FLAGS, 8'h00, "flag cleared");
    endtask

    // =====
    // scenarios
    task automatic t_regs;
        rdchk(`EPI_OFS_SENSE_CTRL, 8'h00, "sense reset");
        rdchk(`EPI_OFS_SENSE_STAT, 8'h00, "status reset");
        rdchk(`EPI_OFS_ENABLES, 8'h00, "enables reset");
        rdchk(`EPI_OFS_FLAGS, 8'h00, "flags reset");
        apb(1'b0, 8'h10, 8'h00);
        check("unmapped error", 32'h1, {31'h0, err});
        wr(`EPI_OFS_SENSE_STAT, 8'hFF);
        rdchk(`EPI_OFS_SENSE_STAT, 8'h40, "polarity only");
        wr(`EPI_OFS_ENABLES, 8'hE0);
        rdchk(`EPI_OFS_ENABLES, 8'hE0, "enables");
        $display("t_regs done");
    endtask

    task automatic t_edges;
        logic [7:0] fb;
        for (int p = 0; p < 2; p++) begin
            fb = (p == 1) ? 8'h80 : 8'h40;
            wr(`EPI_OFS_ENABLES, fb);
            for (int m = 1; m < 4; m++) begin
                wr(`EPI_OFS_SENSE_CTRL, 8'(m * 5));
                rdchk(`EPI_OFS_SENSE_CTRL, 8'(m * 5), "sense fields");
                wr(`EPI_OFS_FLAGS, 8'hE0);
                edge_chk(p, 1'b0, m != 3, fb);
                edge_chk(p, 1'b1, m != 2, fb);
            end
        end
        $display("t_edges done");
    endtask

    task automatic t_level;
        wr(`EPI_OFS_SENSE_CTRL, 8'h00);
        wr(`EPI_OFS_ENABLES, 8'h40);
        i_pins.drive(0, 1'b0);
        wt(5);
        check("level request", 32'h1, {31'h0, vreq[0]});
        rdchk(`EPI_OFS_FLAGS, 8'h00, "level flag");
        ie <= 1'b0;
        wt(2);
        check("global gate", 32'h0, {28'h0, vreq, irq});
        ie <= 1'b1;
        wt(3);
        check("level held", 32'h1, {31'h0, vreq[0]});
        wr(`EPI_OFS_ENABLES, 8'h00);
        wt(2);
        check("pin mask", 32'h0, {29'h0, vreq});
        i_pins.drive(0, 1'b1);
        $display("t_level done");
    endtask

    task automatic t_async(input logic pol);
        // disable, set polarity, clear the flag it may raise, then enable
        wr(`EPI_OFS_ENABLES, 8'h00);
        wr(`EPI_OFS_SENSE_STAT, {1'b0, pol, 6'h0});
        i_pins.drive(2, pol);
        wt(5);
        wr(`EPI_OFS_FLAGS, 8'hE0);
        wr(`EPI_OFS_ENABLES, 8'h20);
        i_pins.drive(2, !pol);
        wt(5);
        check("wrong edge", 32'h0, {31'h0, vreq[2]});
        i_pins.drive(2, pol);
        wt(6);
        check("async request", 32'h1, {31'h0, vreq[2]});
        rdchk(`EPI_OFS_FLAGS, 8'h20, "async flag");
        ack <= 3'h4;
        @(posedge sys_clk_i);
        ack <= 3'h0;
        wt(2);
        check("ack clears", 32'h0, {31'h0, vreq[2]});
        $display("t_async done");
    endtask

    task automatic t_sleep;
        wr(`EPI_OFS_ENABLES, 8'h00);
        wr(`EPI_OFS_SENSE_STAT, 8'h00);
        i_pins.drive(2, 1'b1);
        wt(6);
        wr(`EPI_OFS_FLAGS, 8'hE0);
        sleep_off <= 1'b1;
        wt(6);
        rdchk(`EPI_OFS_FLAGS, 8'h20, "buffer off flag");
        check("masked async", 32'h0, {31'h0, vreq[2]});
        sleep_off <= 1'b0;
        $display("t_sleep done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        wt(4);
        nrst_i <= 1'b1;
        ie <= 1'b1;
        @(posedge sys_clk_i);
        t_regs;
        t_edges;
        t_level;
        t_async(1'b1);
        t_async(1'b0);
        t_sleep;
        summarize;
    end

    // the whole run needs about 550 cycles
    initial begin
        wt(20000);
        $display("ERROR watchdog expected done seen hang");
        mismatches++;
        summarize;
    end
endmodule
